/* File: hdl/fspi_control.v */
// Purpose: framed serial port control with Avalon-MM register access
// Assumes: serial clock, select and data-in come from the peer's domain
// Notes:   transmit words wait in a 32-word buffer ahead of the shifter
`timescale 1ns/1ps
`include "fspi_consts.vh"

// transmit word buffer with valid/ready on both sides
module fspi_fifo #(
	parameter W  = 32,
	parameter D  = 32,
	parameter AW = 5
) (
	// clock and reset
	input wire          core_clk,
	input wire          nrst,
	// fill side
	input wire [W-1:0]  inData,
	input wire          inValid,
	output wire         inReady,
	// drain side
	output wire [W-1:0] outData,
	output wire         outValid,
	input wire          outReady,
	// fill level
	output wire [AW:0]  level
);
	localparam [AW:0] FULLC = D;
	reg  [W-1:0]  mem [0:D-1];
	reg  [AW-1:0] wrPtr_q;
	reg  [AW-1:0] rdPtr_q;
	reg  [AW:0]   count_q;
	wire          doPush;
	wire          doPop;

	// handshakes and flags
	assign inReady  = (count_q != FULLC);
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign doPush   = inValid & inReady;
	assign doPop    = outValid & outReady;
	assign outData  = mem[rdPtr_q];
	assign level    = count_q;

	// storage array
	always @(posedge core_clk) begin
		if (doPush) begin
			mem[wrPtr_q] <= inData;
		end
	end

	// pointers and count
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (doPush) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (doPop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
			if (doPush & ~doPop) begin
				count_q <= count_q + 1'b1;
			end else if (doPop & ~doPush) begin
				count_q <= count_q - 1'b1;
			end
		end
	end
endmodule

// control register, frame sync generation and character shifter
module fspi_control (
	// clock and reset
	input wire         core_clk,
	input wire         nrst,
	// avalon-mm slave
	input wire [3:0]   avsAddress,
	input wire         avsRead,
	input wire         avsWrite,
	input wire [31:0]  avsWriteData,
	input wire [3:0]   avsByteEnable,
	output wire        avsWaitRequest,
	output wire [31:0] avsReadData,
	// serial link
	input wire         serialClk,
	input wire         serialDataIn,
	output wire        serialDataOut,
	// slave select / frame sync pin
	input wire         slaveSelectPinIn,
	output wire        slaveSelectPinOut,
	output wire        slaveSelectPinOe
);
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_LEAD  = 3'b010;
	localparam [2:0] ST_SHIFT = 3'b100;

	reg  [31:0] ctrl_q;
	reg  [31:0] ctrl_d;
	reg  [31:0] rdData_q;
	reg         rdAck_q;
	reg  [31:0] readMux;
	reg  [2:0]  state_q;
	reg  [31:0] txSh_q;
	reg  [31:0] rxSh_q;
	reg  [31:0] rxData_q;
	reg  [5:0]  bitCnt_q;
	reg  [4:0]  charCnt_q;
	reg         syncAct_q;
	reg         run_q;
	reg         sckS1_q, sckS2_q, sckPrev_q;
	reg         sdiS1_q, sdiS2_q;
	reg         ssS1_q, ssS2_q;
	reg  [31:0] aligned;
	wire [31:0] beMask;
	wire        ctrlWr, dataWr, fillValid, fillReady, bufReady;
	wire [31:0] fifoData;
	wire        fifoValid, popNow, startOk;
	wire [5:0]  fifoLevel;
	wire        framed, syncDirIn, syncPol, msAuto, pwChar, edgeSel;
	wire        enhanced_buffer_enable, portOn, master, cke, launchOnFall;
	wire        sckRise, sckFall, launchEdge, sampleEdge, syncInAct;
	wire [2:0]  cntCode;
	wire [5:0]  charLim6;
	wire [5:0]  width;
	wire        runRise;

	// control field views
	assign framed    = ctrl_q[`FSPI_B_FRAMED];
	assign syncDirIn = ctrl_q[`FSPI_B_SYNCDIR];
	assign syncPol   = ctrl_q[`FSPI_B_SYNCPOL];
	assign msAuto    = ctrl_q[`FSPI_B_MSAUTO];
	assign pwChar    = ctrl_q[`FSPI_B_SYNCPW];
	assign edgeSel   = ctrl_q[`FSPI_B_EDGE];
	assign enhanced_buffer_enable    = ctrl_q[`FSPI_B_ENH];
	assign portOn    = ctrl_q[`FSPI_B_ON];
	assign master    = ctrl_q[`FSPI_B_MST];
	assign cke       = ctrl_q[`FSPI_B_CKE];
	assign width     = ctrl_q[`FSPI_B_W32] ? `FSPI_W32 :
		(ctrl_q[`FSPI_B_W16] ? `FSPI_W16 : `FSPI_W8);

	// frame count, reserved codes held at the largest count
	assign cntCode  = (ctrl_q[`FSPI_B_CNT_HI:`FSPI_B_CNT_LO] > `FSPI_CNT_MAXC)
		? `FSPI_CNT_MAXC : ctrl_q[`FSPI_B_CNT_HI:`FSPI_B_CNT_LO];
	assign charLim6 = (6'h01 << cntCode) - 6'h01;

	// bus decode with byte lanes
	assign beMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
		{8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};
	assign ctrlWr    = avsWrite & (avsAddress == `FSPI_OFF_CTRL);
	assign dataWr    = avsWrite & (avsAddress == `FSPI_OFF_DATA);
	assign bufReady  = fillReady & (enhanced_buffer_enable | (fifoLevel == 6'h00));
	assign fillValid = dataWr & bufReady;
	// reads wait one cycle; data writes stall while the buffer is full, or while it holds a word with the enhanced buffer off
	assign avsWaitRequest = (avsRead & ~rdAck_q) | (dataWr & ~bufReady);
	assign avsReadData    = rdData_q;

	// next control value
	always @* begin
		ctrl_d = ctrl_q;
		if (ctrlWr) begin
			ctrl_d = ((ctrl_q & ~beMask) | (avsWriteData & beMask))
				& `FSPI_CTRL_WMASK;
			if (portOn) begin
				ctrl_d[`FSPI_B_ENH] = ctrl_q[`FSPI_B_ENH];
			end
		end
	end

	// read data source
	always @* begin
		readMux = 32'h0000_0000;
		case (avsAddress)
			`FSPI_OFF_CTRL: readMux = ctrl_q;
			`FSPI_OFF_DATA: readMux = rxData_q;
			`FSPI_OFF_STAT: begin
				readMux[`FSPI_S_CNT_HI:`FSPI_S_CNT_LO] = charCnt_q;
				readMux[`FSPI_S_LVL_HI:`FSPI_S_LVL_LO] = fifoLevel;
				readMux[`FSPI_S_BUSY]  = (state_q != ST_IDLE);
				readMux[`FSPI_S_FULL]  = ~fillReady;
				readMux[`FSPI_S_EMPTY] = ~fifoValid;
			end
			default: readMux = 32'h0000_0000;
		endcase
	end

	// registers and read answer
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_q   <= `FSPI_CTRL_RST;
			rdData_q <= 32'h0000_0000;
			rdAck_q  <= 1'b0;
		end else begin
			ctrl_q  <= ctrl_d;
			rdAck_q <= avsRead & ~rdAck_q;
			if (avsRead & ~rdAck_q) begin
				rdData_q <= readMux;
			end
		end
	end

	// two-stage synchronisers for pins from the peer
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sckS1_q   <= 1'b0;
			sckS2_q   <= 1'b0;
			sckPrev_q <= 1'b0;
			sdiS1_q   <= 1'b0;
			sdiS2_q   <= 1'b0;
			ssS1_q    <= 1'b0;
			ssS2_q    <= 1'b0;
		end else begin
			sckS1_q   <= serialClk;
			sckS2_q   <= sckS1_q;
			sckPrev_q <= sckS2_q;
			sdiS1_q   <= serialDataIn;
			sdiS2_q   <= sdiS1_q;
			ssS1_q    <= slaveSelectPinIn;
			ssS2_q    <= ssS1_q;
		end
	end

	// link clock edges; framing forces the fixed edge pairing
	assign sckRise      = sckS2_q & ~sckPrev_q;
	assign sckFall      = ~sckS2_q & sckPrev_q;
	assign launchOnFall = framed | cke;
	assign launchEdge   = launchOnFall ? sckFall : sckRise;
	assign sampleEdge   = launchOnFall ? sckRise : sckFall;
	assign syncInAct    = (ssS2_q == syncPol);

	// start of a character
	assign startOk = portOn & fifoValid &
		(~(framed & syncDirIn) | syncInAct);
	assign popNow  = (state_q == ST_IDLE) & startOk;
	assign runRise = framed & portOn & ~run_q;

	// transmit word placed at the top of the shifter
	always @* begin
		aligned = {fifoData[7:0], 24'h00_0000};
		if (width == `FSPI_W32) begin
			aligned = fifoData;
		end else if (width == `FSPI_W16) begin
			aligned = {fifoData[15:0], 16'h0000};
		end
	end

	// character shifter and frame sync sequencing
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			state_q   <= ST_IDLE;
			txSh_q    <= 32'h0000_0000;
			rxSh_q    <= 32'h0000_0000;
			rxData_q  <= 32'h0000_0000;
			bitCnt_q  <= 6'h00;
			charCnt_q <= 5'h00;
			syncAct_q <= 1'b0;
			run_q     <= 1'b0;
		end else begin
			run_q <= framed & portOn;
			case (state_q)
				ST_IDLE: begin
					if (startOk) begin
						txSh_q   <= aligned;
						rxSh_q   <= 32'h0000_0000;
						bitCnt_q <= 6'h00;
						if (framed & ~syncDirIn) begin
							syncAct_q <= (charCnt_q == 5'h00);
						end else begin
							syncAct_q <= ~framed & master & msAuto;
						end
						if (framed & ~syncDirIn & ~edgeSel &
							(charCnt_q == 5'h00)) begin
							state_q <= ST_LEAD;
						end else begin
							state_q <= ST_SHIFT;
						end
					end
				end
				ST_LEAD: begin
					if (launchEdge) begin
						if (~pwChar) begin
							syncAct_q <= 1'b0;
						end
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (sampleEdge) begin
						rxSh_q   <= {rxSh_q[30:0], sdiS2_q};
						bitCnt_q <= bitCnt_q + 6'h01;
					end else if (launchEdge && bitCnt_q != 6'h00) begin
						if (bitCnt_q == width) begin
							rxData_q  <= rxSh_q;
							syncAct_q <= 1'b0;
							state_q   <= ST_IDLE;
							if (framed) begin
								// a count left above a newly smaller limit wraps
								charCnt_q <= (charCnt_q >= charLim6[4:0])
									? 5'h00 : charCnt_q + 5'h01;
							end
						end else begin
							txSh_q <= {txSh_q[30:0], 1'b0};
							if (framed & ~pwChar) begin
								syncAct_q <= 1'b0;
							end
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
			if (runRise) begin
				charCnt_q <= 5'h00;
			end
		end
	end

	// pin drive: sync or auto select, polarity from the sync bit
	assign serialDataOut     = txSh_q[31];
	assign slaveSelectPinOut = syncAct_q ? syncPol : ~syncPol;
	assign slaveSelectPinOe  = portOn & ((framed & ~syncDirIn) |
		(~framed & master & msAuto));

	// transmit buffer
	fspi_fifo #(
		.W  (`FSPI_DATA_W),
		.D  (`FSPI_DEPTH),
		.AW (`FSPI_AW)
	) u_txbuf (
		.core_clk (core_clk),
		.nrst     (nrst),
		.inData   (avsWriteData),
		.inValid  (fillValid),
		.inReady  (fillReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (popNow),
		.level    (fifoLevel)
	);
endmodule

/* File: hdl/fspi_consts.vh */
// Purpose: shared constants of the framed serial port control block
// Assumes: byte addresses on a 4-bit Avalon-MM address
// Notes:   definitions only
`ifndef FSPI_CONSTS_VH
`define FSPI_CONSTS_VH
// register byte offsets
`define FSPI_OFF_CTRL   4'h0
`define FSPI_OFF_DATA   4'h4
`define FSPI_OFF_STAT   4'h8
// control register reset value and writable bits
`define FSPI_CTRL_RST   32'h0000_0000
`define FSPI_CTRL_WMASK 32'hFF03_BFEF
// control field positions
`define FSPI_B_FRAMED   31
`define FSPI_B_SYNCDIR  30
`define FSPI_B_SYNCPOL  29
`define FSPI_B_MSAUTO   28
`define FSPI_B_SYNCPW   27
`define FSPI_B_CNT_HI   26
`define FSPI_B_CNT_LO   24
`define FSPI_B_EDGE     17
`define FSPI_B_ENH      16
`define FSPI_B_ON       15
`define FSPI_B_W32      11
`define FSPI_B_W16      10
`define FSPI_B_CKE      8
`define FSPI_B_MST      5
// status field positions
`define FSPI_S_CNT_HI   20
`define FSPI_S_CNT_LO   16
`define FSPI_S_LVL_HI   13
`define FSPI_S_LVL_LO   8
`define FSPI_S_BUSY     2
`define FSPI_S_FULL     1
`define FSPI_S_EMPTY    0
// character widths and frame count limit
`define FSPI_W8         6'h08
`define FSPI_W16        6'h10
`define FSPI_W32        6'h20
`define FSPI_CNT_MAXC   3'h5
// transmit buffer shape
`define FSPI_DATA_W     32
`define FSPI_DEPTH      32
`define FSPI_AW         5
`endif

/* File: verif/fspi_monitor.sv */
// Purpose: port checks of the framed serial port control
// Assumes: control writes use all byte lanes
// Notes:   keeps a shadow copy of the control register
`timescale 1ns/1ps
`include "fspi_consts.vh"
module fspi_monitor (
	// clock and reset
	input wire        core_clk,
	input wire        nrst,
	// register bus
	input wire [3:0]  avsAddress,
	input wire        avsRead,
	input wire        avsWrite,
	input wire [31:0] avsWriteData,
	input wire        avsWaitRequest,
	input wire [31:0] avsReadData,
	// select pin
	input wire        slaveSelectPinOut,
	input wire        slaveSelectPinOe
);
	reg  [31:0] ctl_q;
	reg  [5:0]  act_q;
	wire        rdDone = avsRead && !avsWaitRequest;
	wire        ctlWr = avsWrite && !avsWaitRequest && avsAddress == 4'h0;
	wire        syncOn = slaveSelectPinOe && slaveSelectPinOut == ctl_q[29];
	wire        frMst = ctl_q[31] && !ctl_q[30];
	wire        autoM = !ctl_q[31] && ctl_q[28] && ctl_q[5];
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// shadow control and length of the active select run
	always @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			ctl_q <= 32'h0000_0000;
			act_q <= 6'h00;
		end else begin
			if (ctlWr) begin
				ctl_q <= avsWriteData & `FSPI_CTRL_WMASK;
				ctl_q[16] <= ctl_q[15] ? ctl_q[16] : avsWriteData[16];
			end
			act_q <= !syncOn ? 6'h00 : act_q + {5'h00, act_q != 6'h3F};
		end
	end
	a_ctl_readback: assert property (
		rdDone && avsAddress == 4'h0 |-> avsReadData == ctl_q)
		else $error("control readback wrong");
	a_oe_idle: assert property (
		!ctl_q[31] && !ctl_q[28] |-> !slaveSelectPinOe)
		else $error("select driven while unused");
	a_sync_input: assert property (
		ctl_q[31] && ctl_q[30] |-> !slaveSelectPinOe)
		else $error("sync driven in input mode");
	a_sync_drive: assert property (
		frMst && ctl_q[15] |-> slaveSelectPinOe)
		else $error("sync not driven in output mode");
	a_sync_level: assert property (
		frMst && !ctl_q[15] |-> slaveSelectPinOut == !ctl_q[29])
		else $error("idle sync level wrong");
	a_sync_short: assert property (
		frMst && !ctl_q[27] |-> act_q < 6'h20)
		else $error("short sync pulse too long");
	a_auto_drive: assert property (
		autoM && ctl_q[15] |-> slaveSelectPinOe)
		else $error("auto select not driven");
	a_auto_level: assert property (
		autoM && !ctl_q[15] |-> slaveSelectPinOut == !ctl_q[29])
		else $error("idle select level wrong");
	c_frame_pulse: cover property (frMst && $rose(syncOn));
	c_auto_char: cover property (autoM && $rose(syncOn));
	c_full: cover property (rdDone && avsAddress == 4'h8 && avsReadData[1]);
endmodule

bind fspi_control fspi_monitor u_fspi_monitor (
	.core_clk(core_clk), .nrst(nrst), .avsAddress(avsAddress),
	.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
	.avsWaitRequest(avsWaitRequest), .avsReadData(avsReadData),
	.slaveSelectPinOut(slaveSelectPinOut),
	.slaveSelectPinOe(slaveSelectPinOe)
);

/* File: verif/fspi_peer.sv */
// Purpose: behavioural serial peer clocking one character at a time
// Assumes: device launches on falling and samples on rising edges
// Notes:   clock stands low between characters
`timescale 1ns/1ps
module fspi_peer (
	// serial link
	output logic serialClk,
	output logic serialDataIn,
	input wire   serialDataOut,
	// select pin
	output logic slaveSelectDrive,
	input wire   slaveSelectPinOut
);
	// idle levels
	initial begin
		serialClk = 1'b0;
		serialDataIn = 1'b0;
		slaveSelectDrive = 1'b1;
	end
	// n bits msb first, 400 ns bit period, select seen at first/last rise
	task xfer(input int n, input logic [31:0] tx, input logic drv,
		input logic pol, output logic [31:0] rx, output logic ssFirst,
		output logic ssLast);
		int i;
		rx = 32'h0000_0000;
		if (drv)
			slaveSelectDrive = pol;
		#400;
		for (i = 0; i < n; i++) begin
			serialDataIn = tx[n-1-i];
			#200 serialClk = 1'b1;
			rx = {rx[30:0], serialDataOut};
			if (i == 0)
				ssFirst = slaveSelectPinOut;
			ssLast = slaveSelectPinOut;
			#200 serialClk = 1'b0;
		end
		slaveSelectDrive = 1'b1;
		serialDataIn = !serialDataIn; // released line shows the inverse
		#800;
	endtask
endmodule

/* File: verif/fspi_control_tb.sv */
// Purpose: self-checking bench of the framed serial port control
// Assumes: peer model clocks every character, 8-bit width
// Notes:   status checks mask the character counter
`timescale 1ns/1ps
`include "fspi_consts.vh"
module fspi_control_tb;
	logic        core_clk;
	logic        nrst;
	logic [3:0]  avsAddress;
	logic        avsRead;
	logic        avsWrite;
	logic [31:0] avsWriteData;
	wire         avsWaitRequest;
	wire  [31:0] avsReadData;
	wire         serialClk;
	wire         serialDataIn;
	wire         serialDataOut;
	wire         ssDrive;
	wire         slaveSelectPinOut;
	wire         slaveSelectPinOe;
	wire         ssPin;
	int          errCount = 0;
	int          nTests = 0;
	// pin level from both drivers
	assign ssPin = slaveSelectPinOe ? slaveSelectPinOut : ssDrive;
	fspi_control u_fspi_control (
		.core_clk(core_clk), .nrst(nrst), .avsAddress(avsAddress),
		.avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
		.avsByteEnable(4'hF), .avsWaitRequest(avsWaitRequest),
		.avsReadData(avsReadData), .serialClk(serialClk),
		.serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
		.slaveSelectPinIn(ssPin), .slaveSelectPinOut(slaveSelectPinOut),
		.slaveSelectPinOe(slaveSelectPinOe));
	fspi_peer u_fspi_peer (
		.serialClk(serialClk), .serialDataIn(serialDataIn),
		.serialDataOut(serialDataOut), .slaveSelectDrive(ssDrive),
		.slaveSelectPinOut(slaveSelectPinOut));
	// 20 MHz core clock
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		nTests++;
		if (g !== e) begin
			errCount++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	// one transfer held until waitrequest low; an idle cycle follows
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		logic w;
		@(posedge core_clk);
		avsAddress <= a;
		avsWriteData <= d;
		avsWrite <= wr;
		avsRead <= !wr;
		// answer read where settled, it acts at the following rising edge
		do begin
			@(negedge core_clk);
			w = avsWaitRequest;
			q = avsReadData;
			@(posedge core_clk);
		end while (w !== 1'b0);
		avsWrite <= 1'b0;
		avsRead <= 1'b0;
	endtask
	task put(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task get(input string nm, input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(nm, e, q & m);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// watchdog
	initial begin
		#3000000;
		errCount++;
		report_and_stop();
	end
	// main sequence
	initial begin
		logic [31:0] rx;
		logic [31:0] e;
		logic        s0;
		logic        s1;
		int          c;
		int          i;
		nrst = 1'b0;
		avsAddress = 4'h0;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsWriteData = 32'h0000_0000;
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		get("ctl reset", 4'h0, 32'hFFFF_FFFF, `FSPI_CTRL_RST);
		get("unmapped", 4'hC, 32'hFFFF_FFFF, 32'h0000_0000);
		put(4'h0, 32'hFFFF_FFFF);
		get("ctl ones", 4'h0, 32'hFFFF_FFFF, `FSPI_CTRL_WMASK);
		put(4'h0, 32'h0000_0000);
		get("enh held", 4'h0, 32'hFFFF_FFFF, 32'h0001_0000);
		put(4'h0, 32'h0000_0000);
		get("enh free", 4'h0, 32'hFFFF_FFFF, 32'h0000_0000);
		$display("test registers done");
		put(4'h0, 32'h1500_0120);
		put(4'h0, 32'h1500_8120);
		for (i = 0; i < 2; i++) begin
			put(4'h4, 32'h0000_00A5 ^ i);
			u_fspi_peer.xfer(8, 32'h3C + i, 1'b0, 1'b0, rx, s0, s1);
			chk("auto tx", 32'h0000_00A5 ^ i, rx);
			chk("auto sel", 32'h0000_0000, {30'h0, s0, s1});
			get("auto rx", 4'h4, 32'h0000_00FF, 32'h3C + i);
		end
		$display("test auto select done");
		for (c = 0; c < 6; c++) begin
			put(4'h0, 32'hA002_0000 | (c << 24));
			put(4'h0, 32'hA002_8000 | (c << 24));
			for (i = 0; i <= (1 << c); i++) begin
				put(4'h4, i);
				u_fspi_peer.xfer(8, 32'h0000_0000, 1'b0, 1'b1, rx, s0, s1);
				chk("frame tx", i, rx);
				e = ((i % (1 << c)) == 0) ? 32'h0000_0002 : 32'h0000_0000;
				chk("sync", e, {30'h0, s0, s1});
			end
		end
		put(4'h0, 32'h8802_0000);
		put(4'h0, 32'h8802_8000);
		put(4'h4, 32'h0000_0077);
		u_fspi_peer.xfer(8, 32'h0000_0000, 1'b0, 1'b0, rx, s0, s1);
		chk("wide sync", 32'h0000_0000, {30'h0, s0, s1});
		put(4'h0, 32'hA000_0000);
		put(4'h0, 32'hA000_8000);
		put(4'h4, 32'h0000_00C3);
		u_fspi_peer.xfer(9, 32'h0000_0000, 1'b0, 1'b1, rx, s0, s1);
		chk("lead tx", 32'h0000_01C3, rx);
		chk("lead sync", 32'h0000_0002, {30'h0, s0, s1});
		$display("test framed master done");
		put(4'h0, 32'hC000_8000);
		put(4'h4, 32'h0000_005A);
		get("await sync", 4'h8, 32'h0000_0007, 32'h0000_0000);
		u_fspi_peer.xfer(8, 32'h0000_0096, 1'b1, 1'b0, rx, s0, s1);
		chk("slave tx", 32'h0000_005A, rx);
		get("slave rx", 4'h4, 32'h0000_00FF, 32'h0000_0096);
		$display("test framed slave done");
		put(4'h0, 32'h0000_0000);
		put(4'h0, 32'h0001_0100);
		for (i = 0; i < `FSPI_DEPTH; i++)
			put(4'h4, i + 64);
		get("full", 4'h8, 32'h0000_3F07, 32'h0000_2002);
		put(4'h0, 32'h0001_8100);
		for (i = 0; i < `FSPI_DEPTH; i++) begin
			u_fspi_peer.xfer(8, 32'h0000_0000, 1'b0, 1'b0, rx, s0, s1);
			chk("drain", i + 64, rx);
		end
		get("empty", 4'h8, 32'h0000_3F07, 32'h0000_0001);
		$display("test buffer done");
		report_and_stop();
	end
endmodule
